// file: core/nvmcr_core.v
`timescale 1ns/1ps
`include "nvmcr_defs.vh"

module nvmcr_core #(
    parameter [23:0]  PART_IDENT  = 24'h5A5AA5,  // Arbitrary value
    parameter [15:0]  GAIN_CAL    = 16'h0100,
    parameter [15:0]  OFFSET_CAL  = 16'h0000,
    parameter [127:0] SERIAL      = 128'h0123456789ABCDEF0123456789ABCDEF,
    parameter [7:0]   LOAD_DELAY  = `NVMCR_LOAD_DELAY
) (
    input  wire        mclk_i,
    input  wire        reset_n_i,
    input  wire        por_n_i,
    input  wire        part_locked_i,

    input  wire        cpu_req_i,
    input  wire        cpu_we_i,
    input  wire [1:0]  cpu_space_i,
    input  wire [4:0]  cpu_addr_i,
    input  wire [7:0]  cpu_wdata_i,
    output wire        cpu_ack_o,
    output wire [7:0]  cpu_rdata_o,

    input  wire        dbg_req_i,
    input  wire        dbg_we_i,
    input  wire [1:0]  dbg_space_i,
    input  wire [4:0]  dbg_addr_i,
    input  wire [7:0]  dbg_wdata_i,
    output wire        dbg_ack_o,
    output wire        dbg_refused_o,
    output wire [7:0]  dbg_rdata_o,

    output wire        config_loaded_o,
    output wire [3:0]  wdt_window_o,
    output wire [3:0]  wdt_period_o,
    output wire [2:0]  bod_threshold_level_o,
    output wire        bod_sample_rate_sel_o,
    output wire [1:0]  bod_active_mode_o,
    output wire [1:0]  bod_sleep_mode_o,
    output wire [3:0]  osc_select_o,
    output wire [7:0]  system_config0_o,
    output wire [2:0]  startup_delay_o,
    output wire [7:0]  code_region_blocks_o,
    output wire [7:0]  boot_region_blocks_o,
    output wire [1:0]  protect_level_o,
    output wire        nvm_protect_o
);

    localparam [1:0] ST_WAIT = 2'h0;
    localparam [1:0] ST_LOAD = 2'h1;
    localparam [1:0] ST_RUN  = 2'h2;

    // Factory contents and implemented-bit mask of the fuse store
    localparam [95:0] FUSE_DEFAULT = `NVMCR_FUSE_DEFAULT;
    localparam [95:0] FUSE_MASK    = `NVMCR_FUSE_MASK;

    reg  [95:0]  fuse_reg;
    reg  [255:0] customer_reg;
    reg  [1:0]   state_reg;
    reg  [1:0]   state_next;
    reg  [7:0]   cnt_reg;
    reg  [7:0]   cnt_next;

    reg          cpu_ack_reg;
    reg  [7:0]   cpu_rdata_reg;
    reg  [7:0]   cpu_rdata_next;
    reg          dbg_ack_reg;
    reg          dbg_refused_reg;
    reg  [7:0]   dbg_rdata_reg;
    reg  [7:0]   dbg_rdata_next;

    reg  [3:0]   wdt_window_reg;
    reg  [3:0]   wdt_period_reg;
    reg  [2:0]   bod_level_reg;
    reg          bod_sample_reg;
    reg  [1:0]   bod_active_reg;
    reg  [1:0]   bod_sleep_reg;
    reg  [3:0]   osc_sel_reg;
    reg  [7:0]   sys0_reg;
    reg  [2:0]   sut_reg;
    reg  [7:0]   code_blocks_reg;
    reg  [7:0]   boot_blocks_reg;
    reg  [1:0]   prot_level_reg;
    reg          key_match_reg;

    wire [7:0]   fuse_wdt   = fuse_reg[8*`NVMCR_FUSE_WDT +: 8];
    wire [7:0]   fuse_bod   = fuse_reg[8*`NVMCR_FUSE_BOD +: 8];
    wire [7:0]   fuse_osc   = fuse_reg[8*`NVMCR_FUSE_OSC +: 8];
    wire [7:0]   fuse_sys0  = fuse_reg[8*`NVMCR_FUSE_SYS0 +: 8];
    wire [7:0]   fuse_sys1  = fuse_reg[8*`NVMCR_FUSE_SYS1 +: 8];
    wire [7:0]   fuse_code  = fuse_reg[8*`NVMCR_FUSE_CODE +: 8];
    wire [7:0]   fuse_boot  = fuse_reg[8*`NVMCR_FUSE_BOOT +: 8];
    wire [15:0]  fuse_lock  = fuse_reg[8*`NVMCR_FUSE_LOCK +: 16];
    wire         load_now   = (state_reg == ST_LOAD);

    // Access decodes
    wire         cpu_cust_wr = cpu_req_i & cpu_we_i & (cpu_space_i == `NVMCR_SPACE_CUSTOMER);
    wire         dbg_cust_wr = dbg_req_i & dbg_we_i & (dbg_space_i == `NVMCR_SPACE_CUSTOMER);
    wire         dbg_fuse_wr = dbg_req_i & dbg_we_i & (dbg_space_i == `NVMCR_SPACE_FUSE);
    wire         dbg_cust_rd = dbg_req_i & ~dbg_we_i & (dbg_space_i == `NVMCR_SPACE_CUSTOMER);

    // Identification row is read-only: no write path reaches it
    // Reserved bytes read zero
    function [7:0] ident_byte;
        input [4:0] addr;
        reg   [4:0] rel;
        begin
            rel = addr - `NVMCR_OFF_SERIAL;
            ident_byte = 8'h00;
            if (addr >= `NVMCR_OFF_SERIAL) begin
                ident_byte = SERIAL[8*rel[3:0] +: 8];
            end else if (addr < `NVMCR_OFF_PART_IDENT + 5'h03) begin
                ident_byte = PART_IDENT[8*addr[1:0] +: 8];
            end else if (addr >= `NVMCR_OFF_THERMAL_CAL &&
                         addr < `NVMCR_OFF_THERMAL_CAL + 5'h04) begin
                if (addr < `NVMCR_OFF_THERMAL_CAL + `NVMCR_OFF_CAL_STEP) begin
                    ident_byte = GAIN_CAL[8*addr[0] +: 8];
                end else begin
                    ident_byte = OFFSET_CAL[8*addr[0] +: 8];
                end
            end
        end
    endfunction

    // Common read path for one port
    function [7:0] read_byte;
        input [1:0]   space;
        input [4:0]   addr;
        input [95:0]  fuses;
        input [255:0] cust;
        begin
            read_byte = 8'h00;
            case (space)
                `NVMCR_SPACE_IDENT: begin
                    read_byte = ident_byte(addr);
                end
                `NVMCR_SPACE_CUSTOMER: begin
                    read_byte = cust[8*addr +: 8];
                end
                `NVMCR_SPACE_FUSE: begin
                    if (addr < `NVMCR_FUSE_BYTES) begin
                        read_byte = fuses[8*addr[3:0] +: 8];
                    end
                end
                default: begin
                    read_byte = 8'h00;
                end
            endcase
        end
    endfunction

    // Nonvolatile stores: cleared only at power-on, never by reset or erase
    // Chip erase has no path into either store
    genvar gi;
    generate
        for (gi = 0; gi < `NVMCR_FUSE_BYTES; gi = gi + 1) begin : g_fuse
            wire fuse_we = dbg_fuse_wr && (dbg_addr_i == gi);
            always @(posedge mclk_i or negedge por_n_i) begin
                if (!por_n_i) begin
                    fuse_reg[8*gi +: 8] <= FUSE_DEFAULT[8*gi +: 8];
                end else if (fuse_we) begin
                    // Unimplemented bits are dropped
                    fuse_reg[8*gi +: 8] <= dbg_wdata_i & FUSE_MASK[8*gi +: 8];
                end
            end
        end
        for (gi = 0; gi < 32; gi = gi + 1) begin : g_customer
            wire dbg_we = dbg_cust_wr && (dbg_addr_i == gi);
            wire cpu_we = cpu_cust_wr && (cpu_addr_i == gi);
            always @(posedge mclk_i or negedge por_n_i) begin
                if (!por_n_i) begin
                    customer_reg[8*gi +: 8] <= `NVMCR_CUSTOMER_ERASED;
                end else if (dbg_we) begin
                    customer_reg[8*gi +: 8] <= dbg_wdata_i;
                end else if (cpu_we) begin
                    customer_reg[8*gi +: 8] <= cpu_wdata_i;
                end
            end
        end
    endgenerate

    // Read data of each port, chosen ahead of the answer edge
    always @* begin
        cpu_rdata_next = read_byte(cpu_space_i, cpu_addr_i, fuse_reg, customer_reg);
        dbg_rdata_next = read_byte(dbg_space_i, dbg_addr_i, fuse_reg, customer_reg);
        if (dbg_cust_rd && part_locked_i) begin
            dbg_rdata_next = 8'h00;
        end
    end

    // Bus answers, one cycle after the request
    always @(posedge mclk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            cpu_ack_reg   <= 1'b0;
            cpu_rdata_reg <= 8'h00;
        end else begin
            cpu_ack_reg <= cpu_req_i;
            if (cpu_req_i && !cpu_we_i) begin
                cpu_rdata_reg <= cpu_rdata_next;
            end
        end
    end

    always @(posedge mclk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            dbg_ack_reg     <= 1'b0;
            dbg_refused_reg <= 1'b0;
            dbg_rdata_reg   <= 8'h00;
        end else begin
            dbg_ack_reg     <= dbg_req_i;
            dbg_refused_reg <= dbg_cust_rd & part_locked_i;
            if (dbg_req_i && !dbg_we_i) begin
                dbg_rdata_reg <= dbg_rdata_next;
            end
        end
    end

    // Start-up sequencer: wait, copy fuses once, then run
    always @* begin
        state_next = state_reg;
        cnt_next   = cnt_reg;
        case (state_reg)
            ST_WAIT: begin
                cnt_next = cnt_reg + 8'h01;
                if (cnt_reg >= LOAD_DELAY - 8'h01) begin
                    state_next = ST_LOAD;
                end
            end
            ST_LOAD: begin
                state_next = ST_RUN;
            end
            ST_RUN: begin
                state_next = ST_RUN;
            end
            default: begin
                state_next = ST_WAIT;
                cnt_next   = 8'h00;
            end
        endcase
    end

    always @(posedge mclk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            state_reg <= ST_WAIT;
            cnt_reg   <= 8'h00;
        end else begin
            state_reg <= state_next;
            cnt_reg   <= cnt_next;
        end
    end

    // Watchdog control A, loaded once and held until the next reset
    always @(posedge mclk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            wdt_window_reg <= 4'h0;
            wdt_period_reg <= 4'h0;
        end else if (load_now) begin
            wdt_window_reg <= fuse_wdt[`NVMCR_WDT_WINDOW];
            wdt_period_reg <= fuse_wdt[`NVMCR_WDT_PERIOD];
        end
    end

    // Brown-out control A: sample rate, active and sleep modes
    always @(posedge mclk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            bod_sample_reg <= 1'b0;
            bod_active_reg <= 2'h0;
            bod_sleep_reg  <= 2'h0;
        end else if (load_now) begin
            bod_sample_reg <= fuse_bod[`NVMCR_BOD_SAMPLE];
            bod_active_reg <= fuse_bod[`NVMCR_BOD_ACTIVE];
            bod_sleep_reg  <= fuse_bod[`NVMCR_BOD_SLEEP];
        end
    end

    // Brown-out control B: threshold level, reserved codes kept
    always @(posedge mclk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            bod_level_reg <= 3'h0;
        end else if (load_now) begin
            bod_level_reg <= fuse_bod[`NVMCR_BOD_LEVEL];
        end
    end

    // Oscillator select
    always @(posedge mclk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            osc_sel_reg <= 4'h0;
        end else if (load_now) begin
            osc_sel_reg <= fuse_osc[`NVMCR_OSC_SEL];
        end
    end

    // System configuration, start-up delay and region sizes
    always @(posedge mclk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            sys0_reg        <= 8'h00;
            sut_reg         <= 3'h0;
            code_blocks_reg <= 8'h00;
            boot_blocks_reg <= 8'h00;
        end else if (load_now) begin
            sys0_reg        <= fuse_sys0;
            sut_reg         <= fuse_sys1[`NVMCR_SYS1_SUT];
            code_blocks_reg <= fuse_code;
            boot_blocks_reg <= fuse_boot;
        end
    end

    // Debug-port lock level and key match
    always @(posedge mclk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            prot_level_reg <= 2'h0;
            key_match_reg  <= 1'b0;
        end else if (load_now) begin
            prot_level_reg <= fuse_lock[`NVMCR_LOCK_LEVEL];
            key_match_reg  <= (fuse_lock[`NVMCR_LOCK_KEY] == `NVMCR_LOCK_KEY_ACTIVE);
        end
    end

    // Bus outputs
    assign cpu_ack_o             = cpu_ack_reg;
    assign cpu_rdata_o           = cpu_rdata_reg;
    assign dbg_ack_o             = dbg_ack_reg;
    assign dbg_refused_o         = dbg_refused_reg;
    assign dbg_rdata_o           = dbg_rdata_reg;

    // Configuration outputs
    assign config_loaded_o       = (state_reg == ST_RUN);
    assign wdt_window_o          = wdt_window_reg;
    assign wdt_period_o          = wdt_period_reg;
    assign bod_threshold_level_o = bod_level_reg;
    assign bod_sample_rate_sel_o = bod_sample_reg;
    assign bod_active_mode_o     = bod_active_reg;
    assign bod_sleep_mode_o      = bod_sleep_reg;
    assign osc_select_o          = osc_sel_reg;
    assign system_config0_o      = sys0_reg;
    assign startup_delay_o       = sut_reg;
    assign code_region_blocks_o  = code_blocks_reg;
    assign boot_region_blocks_o  = boot_blocks_reg;
    assign protect_level_o       = prot_level_reg;
    // Protection only after load and only on a locked part
    assign nvm_protect_o         = key_match_reg & part_locked_i & config_loaded_o;

endmodule // nvmcr_core

// file: core/nvmcr_defs.vh
// What this block does
// - Three read-only part identifier bytes, offsets 0x00-0x02
// - Two read-only calibration words: gain, signed offset
// - Sixteen read-only serial bytes from offset 0x10
// - Customer row of 32 bytes survives chip erase
// - Debug port writes customer row even locked
// - Locked part refuses debug port customer row reads
// - CPU reads and writes customer row freely
// - Both read fuses; only debug port writes
// - Chip erase leaves fuses untouched
// - Fuses copied to targets at start-up end
// - Changed fuses act only after next reset
// - Watchdog fuse loads window and period fields
// - Brown-out bits 7:5 load threshold level
// - Brown-out bit 4 loads sample rate
// - Brown-out bits 3:2 load active mode
// - Brown-out bits 1:0 load sleep mode
// - Lock config acts after load, when locked
// - Key 0xB45 activates memory protection
`ifndef NVMCR_DEFS_VH
`define NVMCR_DEFS_VH

// Address spaces
`define NVMCR_SPACE_IDENT      2'h0
`define NVMCR_SPACE_CUSTOMER   2'h1
`define NVMCR_SPACE_FUSE       2'h2

// Identification row offsets
`define NVMCR_OFF_PART_IDENT   5'h00
`define NVMCR_OFF_THERMAL_CAL  5'h04
`define NVMCR_OFF_CAL_STEP     5'h02
`define NVMCR_OFF_SERIAL       5'h10

// Fuse offsets
`define NVMCR_FUSE_WDT         0
`define NVMCR_FUSE_BOD         1
`define NVMCR_FUSE_OSC         2
`define NVMCR_FUSE_SYS0        5
`define NVMCR_FUSE_SYS1        6
`define NVMCR_FUSE_CODE        7
`define NVMCR_FUSE_BOOT        8
`define NVMCR_FUSE_LOCK        10
`define NVMCR_FUSE_BYTES       12

// Fuse fields
`define NVMCR_WDT_WINDOW       7:4
`define NVMCR_WDT_PERIOD       3:0
`define NVMCR_BOD_LEVEL        7:5
`define NVMCR_BOD_SAMPLE       4
`define NVMCR_BOD_ACTIVE       3:2
`define NVMCR_BOD_SLEEP        1:0
`define NVMCR_OSC_SEL          3:0
`define NVMCR_SYS1_SUT         2:0
`define NVMCR_LOCK_KEY         15:4
`define NVMCR_LOCK_LEVEL       1:0
`define NVMCR_LOCK_KEY_ACTIVE  12'hB45

// Factory values and implemented-bit mask of the fuse store, byte 0 lowest
`define NVMCR_FUSE_DEFAULT     96'h000300000000C00000000000
`define NVMCR_FUSE_MASK        96'hFFF300FFFF07ED00000FFFFF
`define NVMCR_CUSTOMER_ERASED  8'hFF

// Start-up delay before the fuse copy, in clock cycles
`define NVMCR_LOAD_DELAY       8'h04

`endif

// file: dv/nvmcr_asserts.sv
`timescale 1ns/1ps
module nvmcr_asserts #(
    parameter [23:0] PART_IDENT = 24'h5A5AA5
) (
    input logic       mclk_i,
    input logic       reset_n_i,
    input logic       part_locked_i,
    input logic       cpu_req_i,
    input logic       cpu_we_i,
    input logic [1:0] cpu_space_i,
    input logic [4:0] cpu_addr_i,
    input logic       cpu_ack_o,
    input logic [7:0] cpu_rdata_o,
    input logic       dbg_req_i,
    input logic       dbg_we_i,
    input logic [1:0] dbg_space_i,
    input logic       dbg_ack_o,
    input logic       dbg_refused_o,
    input logic [7:0] dbg_rdata_o,
    input logic       config_loaded_o,
    input logic [3:0] wdt_period_o,
    input logic       nvm_protect_o
);
    default clocking @(posedge mclk_i); endclocking
    default disable iff (!reset_n_i);
    chk_cpu_ack_next: assert property (cpu_req_i |=> cpu_ack_o)
        else $error("cpu ack missing");
    chk_dbg_ack_next: assert property (dbg_req_i |=> dbg_ack_o)
        else $error("debug ack missing");
    chk_locked_refuse: assert property (dbg_req_i && !dbg_we_i && dbg_space_i == 2'h1
        && part_locked_i |=> dbg_refused_o && dbg_rdata_o == 8'h00) else $error("no refusal");
    chk_refuse_cause: assert property (dbg_refused_o |-> $past(dbg_req_i && !dbg_we_i
        && part_locked_i && dbg_space_i == 2'h1)) else $error("spurious refusal");
    chk_ident_first: assert property (cpu_req_i && !cpu_we_i && cpu_space_i == 2'h0
        && cpu_addr_i == 5'h00 |=> cpu_rdata_o == PART_IDENT[7:0]) else $error("ident byte");
    chk_config_hold: assert property (config_loaded_o && $past(config_loaded_o)
        |-> $stable(wdt_period_o)) else $error("config changed without reset");
    chk_protect_gate: assert property (nvm_protect_o |-> part_locked_i && config_loaded_o)
        else $error("protection without lock");
    chk_rdata_hold: assert property ($past(!cpu_req_i) |-> $stable(cpu_rdata_o))
        else $error("cpu read data moved");
endmodule // nvmcr_asserts

bind nvmcr_core nvmcr_asserts #(.PART_IDENT(PART_IDENT)) u_chk (
    .mclk_i(mclk_i), .reset_n_i(reset_n_i), .part_locked_i(part_locked_i),
    .cpu_req_i(cpu_req_i), .cpu_we_i(cpu_we_i), .cpu_space_i(cpu_space_i),
    .cpu_addr_i(cpu_addr_i), .cpu_ack_o(cpu_ack_o), .cpu_rdata_o(cpu_rdata_o),
    .dbg_req_i(dbg_req_i), .dbg_we_i(dbg_we_i), .dbg_space_i(dbg_space_i),
    .dbg_ack_o(dbg_ack_o), .dbg_refused_o(dbg_refused_o), .dbg_rdata_o(dbg_rdata_o),
    .config_loaded_o(config_loaded_o), .wdt_period_o(wdt_period_o),
    .nvm_protect_o(nvm_protect_o));

// file: dv/nvmcr_prog_model.sv
`timescale 1ns/1ps
module nvmcr_prog_model (
    input  logic       mclk_i,
    input  logic       ack_i,
    input  logic       refused_i,
    input  logic [7:0] rdata_i,
    output logic       req_o,
    output logic       we_o,
    output logic [1:0] space_o,
    output logic [4:0] addr_o,
    output logic [7:0] wdata_o
);
    initial begin
        req_o = 1'b0;
        we_o = 1'b0;
        space_o = 2'h3;
        addr_o = 5'h00;
        wdata_o = 8'h00;
    end
    // One access; answer taken 1 ns after the taking edge
    task automatic xfer(input logic we, input logic [1:0] sp, input logic [4:0] a,
        input logic [7:0] d, output logic [7:0] rd, output logic rf, output logic ak);
        @(posedge mclk_i);
        #1;
        req_o = 1'b1;
        we_o = we;
        space_o = sp;
        addr_o = a;
        wdata_o = (sp == 2'h2 && a == 5'h0A) ? (d & 8'hF3) : d;
        @(posedge mclk_i);
        #1;
        req_o = 1'b0;
        rd = rdata_i;
        rf = refused_i;
        ak = ack_i;
        wdata_o = ~wdata_o;
        addr_o = ~addr_o;
    endtask
endmodule // nvmcr_prog_model

// file: dv/test_nvm_config_rows.sv
`timescale 1ns/1ps
module test_nvm_config_rows;
    localparam [23:0]  PID = 24'h3C96C3; // Arbitrary value
    localparam [15:0]  GAIN = 16'h1234;
    localparam [15:0]  OFFS = 16'hFF80;
    localparam [127:0] SER = 128'h00112233445566778899AABBCCDDEEFF;
    logic mclk_i = 1'b0, reset_n_i = 1'b0, por_n = 1'b0, locked = 1'b0;
    logic creq = 1'b0, cwe = 1'b0, cack, dreq, dwe, dack, dref, loaded, prot, cak, rf, bsmp;
    logic [1:0] csp = 2'h0, dsp, bact, bslp, plvl;
    logic [4:0] cad = 5'h00, dad;
    logic [7:0] cwd = 8'h00, crd, drd, dwd, prd;
    logic [3:0] wwin, wper, osc;
    logic [2:0] blvl, sut;
    logic [7:0] sys0, code, boot;
    int mismatches = 0;
    int tests_run = 0;
    always #2.5 mclk_i = ~mclk_i;
    nvmcr_core #(.PART_IDENT(PID), .GAIN_CAL(GAIN), .OFFSET_CAL(OFFS), .SERIAL(SER)) dut (
        .mclk_i(mclk_i), .reset_n_i(reset_n_i), .por_n_i(por_n), .part_locked_i(locked),
        .cpu_req_i(creq), .cpu_we_i(cwe), .cpu_space_i(csp), .cpu_addr_i(cad),
        .cpu_wdata_i(cwd), .cpu_ack_o(cack), .cpu_rdata_o(crd), .dbg_req_i(dreq),
        .dbg_we_i(dwe), .dbg_space_i(dsp), .dbg_addr_i(dad), .dbg_wdata_i(dwd),
        .dbg_ack_o(dack), .dbg_refused_o(dref), .dbg_rdata_o(drd), .config_loaded_o(loaded),
        .wdt_window_o(wwin), .wdt_period_o(wper), .bod_threshold_level_o(blvl),
        .bod_sample_rate_sel_o(bsmp), .bod_active_mode_o(bact), .bod_sleep_mode_o(bslp),
        .osc_select_o(osc), .system_config0_o(sys0), .startup_delay_o(sut),
        .code_region_blocks_o(code), .boot_region_blocks_o(boot), .protect_level_o(plvl),
        .nvm_protect_o(prot));
    nvmcr_prog_model prog (.mclk_i(mclk_i), .ack_i(dack), .refused_i(dref), .rdata_i(drd),
        .req_o(dreq), .we_o(dwe), .space_o(dsp), .addr_o(dad), .wdata_o(dwd));
    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        tests_run++;
        if (seen !== exp) begin
            mismatches++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic wrap_up;
        $display("checks %0d mismatches %0d", tests_run, mismatches);
        if (mismatches == 0 && tests_run > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    task automatic cpu(input logic we, input logic [1:0] sp, input logic [4:0] a,
        input logic [7:0] d);
        @(posedge mclk_i);
        #1;
        creq = 1'b1;
        cwe = we;
        csp = sp;
        cad = a;
        cwd = d;
        @(posedge mclk_i);
        #1;
        creq = 1'b0;
        check("cpu ack", cack, 1'b1);
    endtask
    task automatic dbg(input logic we, input logic [1:0] sp, input logic [4:0] a,
        input logic [7:0] d);
        prog.xfer(we, sp, a, d, prd, rf, cak);
        check("debug ack", cak, 1'b1);
    endtask
    task automatic do_reset(input int n);
        int k;
        reset_n_i = 1'b0;
        repeat (n) @(posedge mclk_i);
        #1;
        reset_n_i = 1'b1;
        por_n = 1'b1;
        k = 0;
        while (loaded !== 1'b1 && k < 20) begin
            @(posedge mclk_i);
            #1;
            k++;
        end
        check("config load", loaded, 1'b1);
        if (k == 20) wrap_up();
    endtask
    task automatic t_ident;
        logic [255:0] row;
        row = {SER, 64'h0, OFFS, GAIN, 8'h00, PID};
        cpu(1'b1, 2'h0, 5'h00, 8'hFF);
        dbg(1'b1, 2'h0, 5'h05, 8'h00);
        for (int a = 0; a < 32; a++) begin
            cpu(1'b0, 2'h0, a[4:0], 8'h00);
            check("ident row", crd, row[8*a+:8]);
        end
        $display("ident row test done");
    endtask
    task automatic t_customer;
        cpu(1'b1, 2'h1, 5'h1F, 8'h3C);
        cpu(1'b0, 2'h1, 5'h1F, 8'h00);
        check("cpu customer", crd, 8'h3C);
        locked = 1'b1;
        dbg(1'b1, 2'h1, 5'h1F, 8'hA7);
        dbg(1'b0, 2'h1, 5'h1F, 8'h00);
        check("refused", {rf, prd}, 9'h100);
        cpu(1'b0, 2'h1, 5'h1F, 8'h00);
        check("locked write", crd, 8'hA7);
        locked = 1'b0;
        dbg(1'b0, 2'h1, 5'h1F, 8'h00);
        check("debug customer", {rf, prd}, 9'h0A7);
        $display("customer row test done");
    endtask
    task automatic t_fuse;
        logic [7:0] wv, bv, prev;
        logic [1:0] j;
        prev = 8'h00;
        for (int i = 0; i < 4; i++) begin
            j = i[1:0];
            wv = {4'h9 + {2'b0, j}, 4'h6 - {2'b0, j}};
            bv = {1'b0, j, j[0], j, j};
            cpu(1'b1, 2'h2, 5'h00, ~wv);
            dbg(1'b1, 2'h2, 5'h00, wv);
            dbg(1'b1, 2'h2, 5'h01, bv);
            dbg(1'b1, 2'h2, 5'h0A, 8'h5E);
            dbg(1'b1, 2'h2, 5'h0B, j[0] ? 8'hB4 : 8'hB3);
            dbg(1'b1, 2'h2, 5'h02, {6'h00, j});
            check("old config", {wwin, wper}, prev);
            cpu(1'b0, 2'h2, 5'h00, 8'h00);
            check("fuse read", crd, wv);
            do_reset(2);
            check("watchdog", {wwin, wper}, wv);
            check("level", blvl, {1'b0, j});
            check("sample", bsmp, j[0]);
            check("active", bact, j);
            check("sleep", bslp, j);
            check("osc", osc, {2'b00, j});
            check("lock level", plvl, 2'h2);
            locked = 1'b1;
            @(posedge mclk_i);
            #1;
            check("protect", prot, j[0]);
            locked = 1'b0;
            @(posedge mclk_i);
            #1;
            check("unlocked", prot, 1'b0);
            prev = wv;
        end
        $display("fuse test done");
    endtask
    initial begin
        do_reset(12);
        check("osc default", osc, 4'h0);
        check("sys0 default", sys0, 8'hC0);
        check("sut default", sut, 3'h0);
        check("sizes default", {code, boot}, 16'h0000);
        check("level default", plvl, 2'h3);
        t_ident();
        t_customer();
        t_fuse();
        wrap_up();
    end
endmodule // test_nvm_config_rows
